// ==== design/prx_pkg.sv ====
// shared constants of the proximity sensor register port
package prx_pkg;
    localparam logic [6:0] SLAVE_ADDR        = 7'h37;
    localparam logic [7:0] HS_CODE_MASK      = 8'hF8;
    localparam logic [7:0] HS_CODE           = 8'h08;
    // register offsets
    localparam logic [7:0] ADDR_PART_REV     = 8'h00;
    localparam logic [7:0] ADDR_SOFT_RESET   = 8'h01;
    localparam logic [7:0] ADDR_IRQ_PIN_CFG  = 8'h02;
    localparam logic [7:0] ADDR_LED_DIV      = 8'h0D;
    localparam logic [7:0] ADDR_SMP_DELAY    = 8'h0E;
    localparam logic [7:0] ADDR_LED_CURRENT  = 8'h0F;
    localparam logic [7:0] ADDR_UP_TH_HI     = 8'h10;
    localparam logic [7:0] ADDR_UP_TH_LO     = 8'h11;
    localparam logic [7:0] ADDR_LO_TH_HI     = 8'h12;
    localparam logic [7:0] ADDR_LO_TH_LO     = 8'h13;
    localparam logic [7:0] ADDR_FILTER_CFG   = 8'h14;
    localparam logic [7:0] ADDR_INTEG_CFG    = 8'h15;
    localparam logic [7:0] ADDR_INTERVAL_CFG = 8'h16;
    localparam logic [7:0] ADDR_MODE_CTRL    = 8'h17;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h40;
    localparam logic [7:0] ADDR_RESULT_HI    = 8'h41;
    localparam logic [7:0] ADDR_RESULT_LO    = 8'h42;
    // field positions and reset values
    localparam int         SOFT_RESET_BIT    = 0;
    localparam int         PART_NUM_LSB      = 4;
    localparam logic [7:0] RST_IRQ_PIN_CFG   = 8'h02;
    localparam logic [4:0] RST_LED_DIV       = 5'h10;
    localparam logic [4:0] RST_SMP_DELAY     = 5'h05;
    localparam logic [4:0] RST_LED_CURRENT   = 5'h09;
    localparam int         RESULT_BITS       = 12;
    // timing: 4 MHz reference and 125 ns delay step, rounded up to 13 cycles of the 100 MHz clock
    localparam int         CLK_MHZ           = 100;
    localparam int         REF_MHZ           = 4;
    localparam int         REF_DIV_CYC       = CLK_MHZ / REF_MHZ;
    localparam int         DELAY_STEP_NS     = 125;
    localparam int         DELAY_STEP_CYC    = (DELAY_STEP_NS * CLK_MHZ + 999) / 1000;
endpackage

// ==== design/prx_led_timer.sv ====
// LED pulse-rate divider and receiver sample-delay strobe
`timescale 1ns/1ns
module prx_led_timer (
    input  wire logic       ref_clk,     // 100 MHz clock
    input  wire logic       sys_rst,     // async reset, high
    input  wire logic       soft_rst,    // one-cycle soft reset pulse
    input  wire logic [4:0] led_div,     // divider of the 4 MHz reference
    input  wire logic [4:0] smp_delay,   // sample delay code
    output logic            led_pulse,   // modulated LED drive
    output logic            rx_sample    // one-cycle receiver sample strobe
);
    localparam int PW = $clog2(prx_pkg::REF_DIV_CYC);
    localparam int SW = $clog2(prx_pkg::DELAY_STEP_CYC);
    localparam logic [PW-1:0] PRE_MAX = PW'(prx_pkg::REF_DIV_CYC - 1);
    localparam logic [SW-1:0] STEP_MAX = SW'(prx_pkg::DELAY_STEP_CYC - 1);

    logic [PW-1:0] pre_q, pre_d;
    logic [4:0]    div_q, div_d;
    logic          led_q, led_d;
    logic [4:0]    dly_q, dly_d;
    logic [SW-1:0] step_q, step_d;
    logic          arm_q, arm_d;
    logic          smp_q, smp_d;
    logic          tick;
    logic [4:0]    half;
    logic [4:0]    steps;

    assign tick  = (pre_q == PRE_MAX);
    // codes below 2 are treated as 2 so the divider never stalls
    assign half  = (led_div < 5'h02) ? 5'h01 : (led_div >> 1);
    assign steps = (smp_delay < 5'h02) ? 5'h00 : smp_delay - 5'h01;

    always_comb begin
        pre_d  = tick ? '0 : pre_q + PW'(1);
        div_d  = div_q;
        led_d  = led_q;
        dly_d  = dly_q;
        step_d = step_q;
        arm_d  = arm_q;
        smp_d  = 1'b0;
        if (tick) begin
            // edges every half-divisor of the 4 MHz reference
            if (div_q + 5'h01 >= half) begin
                div_d = '0;
                led_d = ~led_q;
                arm_d = 1'b1;
                dly_d = steps;
                step_d = '0;
            end else begin
                div_d = div_q + 5'h01;
            end
        end
        if (arm_q) begin
            if (dly_q == 5'h00) begin
                smp_d = 1'b1;
                arm_d = 1'b0;
            end else if (step_q == STEP_MAX) begin
                step_d = '0;
                dly_d  = dly_q - 5'h01;
            end else begin
                step_d = step_q + SW'(1);
            end
        end
        if (soft_rst) begin
            pre_d = '0;
            div_d = '0;
            led_d = 1'b0;
            arm_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q <= '0;
            div_q <= '0;
            led_q <= 1'b0;
            dly_q <= '0;
            step_q <= '0;
            arm_q <= 1'b0;
            smp_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            div_q <= div_d;
            led_q <= led_d;
            dly_q <= dly_d;
            step_q <= step_d;
            arm_q <= arm_d;
            smp_q <= smp_d;
        end
    end

    assign led_pulse = led_q;
    assign rx_sample = smp_q;
endmodule

// ==== design/prx_pin_sync.sv ====
// two-flop synchroniser and edge detect for the serial bus pins
`timescale 1ns/1ns
module prx_pin_sync (
    input  wire logic ref_clk,   // 100 MHz clock
    input  wire logic sys_rst,   // async reset, high
    input  wire logic pin_i,     // raw pin level
    output logic      level,     // synchronised level
    output logic      rise,      // one-cycle rising edge
    output logic      fall       // one-cycle falling edge
);
    logic [2:0] sh_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) sh_q <= 3'h7;
        else         sh_q <= {sh_q[1:0], pin_i};
    end
    // only stages 1 and 2 are looked at; stage 0 may be metastable
    assign level = sh_q[1];
    assign rise  = sh_q[1] & ~sh_q[2];
    assign fall  = ~sh_q[1] & sh_q[2];
endmodule

// ==== design/prx_i2c_regs.sv ====
// serial bus slave port and register bank of the proximity sensor
`timescale 1ns/1ns
module prx_i2c_regs #(
    parameter logic [3:0] PART_NUM = 4'hA,  // arbitrary part code
    parameter logic [3:0] REV_NUM  = 4'h1   // arbitrary revision code
) (
    input  wire logic        ref_clk,      // 100 MHz clock
    input  wire logic        sys_rst,      // async reset, high (power-up)
    input  wire logic        scl_i,        // serial clock pin level
    input  wire logic        sda_i,        // serial data pin level
    output logic             sda_o,        // serial data drive value (always 0)
    output logic             sda_oe,       // high while pulling data low
    output logic             hs_mode,      // high-speed I/O mode active
    input  wire logic [11:0] meas_result,  // measurement from the converter
    input  wire logic        meas_valid,   // one-cycle strobe, new result
    input  wire logic [7:0]  irq_status,   // interrupt status from irq logic
    output logic             led_pulse,    // LED modulation drive
    output logic             rx_sample,    // receiver sample strobe
    output logic [7:0]       irq_pin_config,          // register copies
    output logic [4:0]       led_pulse_current,
    output logic [15:0]      upper_threshold,
    output logic [15:0]      lower_threshold,
    output logic [7:0]       irq_filter_config,
    output logic [7:0]       integration_time_config,
    output logic [7:0]       measure_interval_config,
    output logic [7:0]       operation_mode_control
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX   = 5'b00010,
        ST_ACK  = 5'b00100,
        ST_TX   = 5'b01000,
        ST_RACK = 5'b10000
    } prx_state_e;

    logic scl, scl_rise, scl_fall, sda, sda_rise, sda_fall;
    logic start_ev, stop_ev;

    prx_pin_sync u_scl (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_i   (scl_i),
        .level   (scl),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );
    prx_pin_sync u_sda (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_i   (sda_i),
        .level   (sda),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    assign start_ev = scl & sda_fall;
    assign stop_ev  = scl & sda_rise;

    prx_state_e  st_q, st_d;
    logic [2:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d;
    logic [1:0]  byte_q, byte_d;     // 0 address, 1 register address, 2 data
    logic        rd_q, rd_d;
    logic        ack_q, ack_d;       // acknowledge about to be driven
    logic        drv_q, drv_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        hs_q, hs_d;
    logic        rst_pend_q, rst_pend_d;
    logic        soft_rst;
    logic        wr_en;
    logic [7:0]  wr_data;

    logic [7:0]  cfg_q, cfg_d;
    logic [4:0]  div_q, div_d, dly_q, dly_d, cur_q, cur_d;
    logic [7:0]  th_q [4], th_d [4];
    logic [7:0]  flt_q, flt_d, int_q, int_d, ivl_q, ivl_d, mode_q, mode_d;
    logic [11:0] res_q, res_d;

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        unique case (a)
            prx_pkg::ADDR_PART_REV:     read_reg = {PART_NUM, REV_NUM};
            prx_pkg::ADDR_IRQ_PIN_CFG:  read_reg = cfg_q;
            prx_pkg::ADDR_LED_DIV:      read_reg = {3'h0, div_q};
            prx_pkg::ADDR_SMP_DELAY:    read_reg = {3'h0, dly_q};
            prx_pkg::ADDR_LED_CURRENT:  read_reg = {3'h0, cur_q};
            prx_pkg::ADDR_UP_TH_HI:     read_reg = th_q[0];
            prx_pkg::ADDR_UP_TH_LO:     read_reg = th_q[1];
            prx_pkg::ADDR_LO_TH_HI:     read_reg = th_q[2];
            prx_pkg::ADDR_LO_TH_LO:     read_reg = th_q[3];
            prx_pkg::ADDR_FILTER_CFG:   read_reg = flt_q;
            prx_pkg::ADDR_INTEG_CFG:    read_reg = int_q;
            prx_pkg::ADDR_INTERVAL_CFG: read_reg = ivl_q;
            prx_pkg::ADDR_MODE_CTRL:    read_reg = mode_q;
            prx_pkg::ADDR_IRQ_STATUS:   read_reg = irq_status;
            prx_pkg::ADDR_RESULT_HI:    read_reg = {4'h0, res_q[11:8]};
            prx_pkg::ADDR_RESULT_LO:    read_reg = res_q[7:0];
            default:                    read_reg = 8'h00;
        endcase
    endfunction

    // bus protocol engine; all changes of the data line happen on scl low
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        byte_d = byte_q;
        rd_d = rd_q;
        ack_d = ack_q;
        drv_d = drv_q;
        ptr_d = ptr_q;
        hs_d = hs_q;
        rst_pend_d = rst_pend_q;
        wr_en = 1'b0;
        wr_data = sh_q;
        soft_rst = 1'b0;
        if (stop_ev) begin
            st_d = ST_IDLE;
            drv_d = 1'b0;
            hs_d = 1'b0;
            soft_rst = rst_pend_q;
            rst_pend_d = 1'b0;
        end else if (start_ev) begin
            // repeated START keeps HS mode and pending reset
            st_d = ST_RX;
            bit_d = 3'h0;
            byte_d = 2'd0;
            drv_d = 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: ;
                ST_RX: if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda};
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        st_d = ST_ACK;
                        ack_d = 1'b1;
                        if (byte_q == 2'd0) begin
                            rd_d = sda;
                            if ((({sh_q[6:0], sda}) & prx_pkg::HS_CODE_MASK)
                                    == prx_pkg::HS_CODE) begin
                                hs_d = 1'b1;
                                ack_d = 1'b0;
                            end else if (sh_q[6:0] != prx_pkg::SLAVE_ADDR) begin
                                ack_d = 1'b0;
                            end
                        end else if (byte_q == 2'd1) begin
                            ptr_d = {sh_q[6:0], sda};
                        end else begin
                            wr_en = 1'b1;
                            wr_data = {sh_q[6:0], sda};
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                ST_ACK: if (scl_fall) begin
                    if (drv_q) begin
                        drv_d = 1'b0;
                        if (rd_q && byte_q == 2'd0) begin
                            st_d = ST_TX;
                            sh_d = read_reg(ptr_q);
                            bit_d = 3'h0;
                            drv_d = ~sh_d[7];
                        end else begin
                            st_d = ST_RX;
                            bit_d = 3'h0;
                            if (byte_q != 2'd2) byte_d = byte_q + 2'd1;
                        end
                    end else if (ack_q) begin
                        drv_d = 1'b1;
                        ack_d = 1'b0;
                    end else begin
                        st_d = ST_IDLE;                         // not for us
                    end
                end
                ST_TX: if (scl_fall) begin
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        st_d = ST_RACK;
                        drv_d = 1'b0;
                        ptr_d = ptr_q + 8'h01;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b0};
                        drv_d = ~sh_q[6];
                    end
                end
                ST_RACK: if (scl_rise) begin
                    if (sda) st_d = ST_IDLE;
                    else begin
                        sh_d = read_reg(ptr_q);
                        bit_d = 3'h0;
                        ack_d = 1'b1;
                    end
                end else if (scl_fall && ack_q) begin
                    // next byte goes out from this fall, like the first one
                    st_d = ST_TX;
                    ack_d = 1'b0;
                    drv_d = ~sh_q[7];
                end
                default: st_d = ST_IDLE;
            endcase
        end
        if (wr_en && ptr_q == prx_pkg::ADDR_SOFT_RESET && wr_data[prx_pkg::SOFT_RESET_BIT])
            rst_pend_d = 1'b1;
    end

    // register bank; writes to read-only or unmapped offsets vanish
    always_comb begin
        cfg_d = cfg_q;
        div_d = div_q;
        dly_d = dly_q;
        cur_d = cur_q;
        th_d = th_q;
        flt_d = flt_q;
        int_d = int_q;
        ivl_d = ivl_q;
        mode_d = mode_q;
        res_d = meas_valid ? meas_result : res_q;
        if (wr_en) begin
            unique case (ptr_q)
                prx_pkg::ADDR_IRQ_PIN_CFG:  cfg_d = wr_data;
                prx_pkg::ADDR_LED_DIV:      div_d = wr_data[4:0];
                prx_pkg::ADDR_SMP_DELAY:    dly_d = wr_data[4:0];
                prx_pkg::ADDR_LED_CURRENT:  cur_d = wr_data[4:0];
                prx_pkg::ADDR_UP_TH_HI:     th_d[0] = wr_data;
                prx_pkg::ADDR_UP_TH_LO:     th_d[1] = wr_data;
                prx_pkg::ADDR_LO_TH_HI:     th_d[2] = wr_data;
                prx_pkg::ADDR_LO_TH_LO:     th_d[3] = wr_data;
                prx_pkg::ADDR_FILTER_CFG:   flt_d = wr_data;
                prx_pkg::ADDR_INTEG_CFG:    int_d = wr_data;
                prx_pkg::ADDR_INTERVAL_CFG: ivl_d = wr_data;
                prx_pkg::ADDR_MODE_CTRL:    mode_d = wr_data;
                default: ;
            endcase
        end
        if (soft_rst) begin
            cfg_d = prx_pkg::RST_IRQ_PIN_CFG;
            div_d = prx_pkg::RST_LED_DIV;
            dly_d = prx_pkg::RST_SMP_DELAY;
            cur_d = prx_pkg::RST_LED_CURRENT;
            th_d = '{default: 8'h00};
            flt_d = 8'h00;
            int_d = 8'h00;
            ivl_d = 8'h00;
            mode_d = 8'h00;
            res_d = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            byte_q <= '0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            ptr_q <= '0;
            hs_q <= 1'b0;
            rst_pend_q <= 1'b0;
            cfg_q <= prx_pkg::RST_IRQ_PIN_CFG;
            div_q <= prx_pkg::RST_LED_DIV;
            dly_q <= prx_pkg::RST_SMP_DELAY;
            cur_q <= prx_pkg::RST_LED_CURRENT;
            th_q <= '{default: 8'h00};
            flt_q <= '0;
            int_q <= '0;
            ivl_q <= '0;
            mode_q <= '0;
            res_q <= '0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            byte_q <= byte_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
            drv_q <= drv_d;
            ptr_q <= ptr_d;
            hs_q <= hs_d;
            rst_pend_q <= rst_pend_d;
            cfg_q <= cfg_d;
            div_q <= div_d;
            dly_q <= dly_d;
            cur_q <= cur_d;
            th_q <= th_d;
            flt_q <= flt_d;
            int_q <= int_d;
            ivl_q <= ivl_d;
            mode_q <= mode_d;
            res_q <= res_d;
        end
    end

    prx_led_timer u_timer (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .soft_rst  (soft_rst),
        .led_div   (div_q),
        .smp_delay (dly_q),
        .led_pulse (led_pulse),
        .rx_sample (rx_sample)
    );

    assign sda_o   = 1'b0;
    assign sda_oe  = drv_q;
    assign hs_mode = hs_q;
    assign irq_pin_config          = cfg_q;
    assign led_pulse_current       = cur_q;
    assign upper_threshold         = {th_q[0], th_q[1]};
    assign lower_threshold         = {th_q[2], th_q[3]};
    assign irq_filter_config       = flt_q;
    assign integration_time_config = int_q;
    assign measure_interval_config = ivl_q;
    assign operation_mode_control  = mode_q;
endmodule

// ==== verification/prx_props.sv ====
// checker of serial port and led timing outputs
`timescale 1ns/1ns
module prx_props (
    input wire logic ref_clk,   // clock
    input wire logic sys_rst,   // reset
    input wire logic scl_i,     // serial clock
    input wire logic sda_o,     // data value
    input wire logic sda_oe,    // data pull
    input wire logic hs_mode,   // high-speed mode
    input wire logic led_pulse, // led drive
    input wire logic rx_sample  // sample strobe
);
    logic       led_q;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // cycles since the last led edge
    always_comb begin
        cnt_d = (led_pulse != led_q) ? 10'h000 : cnt_q + 10'h001;
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            led_q <= 1'b0;
            cnt_q <= 10'h000;
        end else begin
            led_q <= led_pulse;
            cnt_q <= cnt_d;
        end
    end
    property p_sda_low; sda_oe |-> !sda_o; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data driven high");
    property p_oe_scl_low; $changed(sda_oe) |-> !scl_i; endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
    property p_oe_after_fall; $rose(sda_oe) |-> !$past(scl_i, 2); endproperty
    a_oe_after_fall: assert property (p_oe_after_fall) else $error("pull not after fall");
    property p_ack_hold; $rose(sda_oe) |-> sda_oe [*6]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("pull released early");
    property p_hs_fall; $fell(hs_mode) |-> scl_i; endproperty
    a_hs_fall: assert property (p_hs_fall) else $error("fast mode left off stop");
    property p_led_runs; cnt_q < 10'h190; endproperty
    a_led_runs: assert property (p_led_runs) else $error("led stalled");
    property p_rx_pulse; rx_sample |=> !rx_sample; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("sample strobe too long");
    property p_rx_near_led; rx_sample |-> cnt_q <= 10'h18A; endproperty
    a_rx_near_led: assert property (p_rx_near_led) else $error("sample too late");
endmodule
bind prx_i2c_regs prx_props u_prx_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .hs_mode(hs_mode), .led_pulse(led_pulse),
    .rx_sample(rx_sample));

// ==== verification/prx_host_model.sv ====
// serial bus host model with pulled-up data line
`timescale 1ns/1ns
module prx_host_model #(
    parameter int PH = 6  // clocks per phase
) (
    input  wire logic ref_clk, // clock
    input  wire logic sda_oe,  // device pull
    output logic      scl,     // serial clock
    output logic      sda      // resolved data line
);
    logic sda_m;
    assign sda = sda_m & ~sda_oe;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic ph();
        repeat (PH) @(negedge ref_clk);
    endtask
    // also a repeated start when entered with clock low
    task automatic start();
        ph();
        sda_m = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_m = 1'b0;
        ph();
        scl = 1'b0;
    endtask
    task automatic stop();
        ph();
        sda_m = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_m = 1'b1;
        ph();
    endtask
    // data held a full phase after clock fall, so no false start or stop
    task automatic bit_x(input logic b, output logic r);
        ph();
        sda_m = b;
        ph();
        scl = 1'b1;
        ph();
        r = sda;
        scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx[i] = r;
        end
        bit_x(ack_in, r);
        ack = ~r;
    endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the proximity sensor register port
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] AW = {prx_pkg::SLAVE_ADDR, 1'b0};
    logic ref_clk, sys_rst, scl, sda, sda_o, sda_oe, hs_mode, meas_valid, led_pulse, rx_sample;
    logic [11:0] meas_result;
    logic [7:0] irq_status;
    logic [15:0] upper_threshold, lower_threshold;
    logic [31:0] lfsr;
    int err_count, num_checks;
    logic [15:0] exp_q[$];
    logic [15:0] obs_q[$];
    string nm_q[$];
    event obs_ev;
    prx_i2c_regs #(.PART_NUM(4'h3), .REV_NUM(4'h2)) u_prx_i2c_regs ( // arbitrary id codes
        .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .hs_mode(hs_mode), .meas_result(meas_result), .meas_valid(meas_valid),
        .irq_status(irq_status), .led_pulse(led_pulse), .rx_sample(rx_sample),
        .irq_pin_config(), .led_pulse_current(), .upper_threshold(upper_threshold),
        .lower_threshold(lower_threshold), .irq_filter_config(), .integration_time_config(),
        .measure_interval_config(), .operation_mode_control());
    prx_host_model u_prx_host_model (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] v, input logic [15:0] e);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        obs_q.push_back(v);
        ->obs_ev;
    endtask
    // drains all notes: back-to-back checks in one time step trigger only once
    always @(obs_ev) begin
        logic [15:0] e;
        logic [15:0] v;
        string n;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            v = obs_q.pop_front();
            n = nm_q.pop_front();
            num_checks = num_checks + 1;
            if (v !== e) begin
                err_count = err_count + 1;
                $display("ERROR %s expected %h seen %h", n, e, v);
            end
        end
    end
    task automatic st();
        u_prx_host_model.start();
    endtask
    task automatic sp();
        u_prx_host_model.stop();
    endtask
    task automatic sb(input logic [7:0] b, input logic e);
        logic [7:0] rx;
        logic a;
        u_prx_host_model.xfer(b, 1'b1, rx, a);
        chk("ack", {15'h0000, a}, {15'h0000, e});
    endtask
    task automatic rb(input logic [7:0] e, input logic last);
        logic [7:0] rx;
        logic a;
        u_prx_host_model.xfer(8'hFF, last, rx, a);
        chk("read byte", {8'h00, rx}, {8'h00, e});
    endtask
    task automatic rd_at(input logic [7:0] ra);
        st();
        sb(AW, 1'b1);
        sb(ra, 1'b1);
        st();
        sb(AW | 8'h01, 1'b1);
    endtask
    // cycles from a led edge to the next led edge or sample strobe
    task automatic gap(input logic sel, input int lo, input int hi);
        logic l;
        int n;
        int m;
        // sampled at the falling edge, away from the edge that launches them
        l = led_pulse;
        for (m = 0; m < 900 && led_pulse === l; m++) @(negedge ref_clk);
        l = led_pulse;
        for (n = 0; n < 900 && (sel ? rx_sample !== 1'b1 : led_pulse === l); n++)
            @(negedge ref_clk);
        if (m == 900 || n == 900) begin
            err_count = err_count + 1;
            $display("ERROR led wait expected %0d seen %0d", hi, n);
            summarize();
        end else begin
            chk(sel ? "sample delay" : "led half period", 16'(n >= lo && n <= hi), 16'h0001);
        end
    endtask
    initial begin
        sys_rst = 1'b1;
        meas_result = 12'h000;
        meas_valid = 1'b0;
        irq_status = 8'h00;
        err_count = 0;
        num_checks = 0;
        lfsr = 32'h9C80;
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        rd_at(prx_pkg::ADDR_LED_DIV);
        rb(8'h10, 1'b0);
        rb(8'h05, 1'b0);
        rb(8'h09, 1'b1);
        sp();
        gap(1'b0, 200, 200);
        gap(1'b1, 52, 56);
        $display("test defaults done");
        lfsr = nxt(lfsr);
        st();
        sb(AW, 1'b1);
        sb(prx_pkg::ADDR_UP_TH_HI, 1'b1);
        for (int i = 3; i >= 0; i--) sb(lfsr[8*i+:8], 1'b1);
        sp();
        chk("upper threshold", upper_threshold, lfsr[31:16]);
        chk("lower threshold", lower_threshold, lfsr[15:0]);
        rd_at(prx_pkg::ADDR_UP_TH_HI);
        for (int i = 3; i >= 0; i--) rb(lfsr[8*i+:8], i == 0);
        sp();
        $display("test block transfers done");
        st();
        sb(8'h08, 1'b0);
        chk("hs mode", {15'h0000, hs_mode}, 16'h0001);
        st();
        sb(AW, 1'b1);
        sb(prx_pkg::ADDR_LED_DIV, 1'b1);
        sb(8'h08, 1'b1);
        sb(8'h01, 1'b1);
        chk("hs mode", {15'h0000, hs_mode}, 16'h0001);
        sp();
        repeat (4) @(negedge ref_clk);
        chk("hs mode", {15'h0000, hs_mode}, 16'h0000);
        gap(1'b0, 100, 100);
        gap(1'b1, 0, 4);
        st();
        sb(AW, 1'b1);
        sb(prx_pkg::ADDR_SMP_DELAY, 1'b1);
        sb(8'h03, 1'b1);
        sp();
        gap(1'b1, 26, 30);
        $display("test timing done");
        lfsr = nxt(lfsr);
        meas_result = lfsr[11:0];
        irq_status = lfsr[27:20];
        meas_valid = 1'b1;
        @(negedge ref_clk);
        meas_valid = 1'b0;
        st();
        sb(AW, 1'b1);
        sb(prx_pkg::ADDR_RESULT_HI, 1'b1);
        sb(8'hFF, 1'b1);
        sp();
        rd_at(prx_pkg::ADDR_IRQ_STATUS);
        rb(lfsr[27:20], 1'b0);
        rb({4'h0, lfsr[11:8]}, 1'b0);
        rb(lfsr[7:0], 1'b1);
        sp();
        rd_at(prx_pkg::ADDR_PART_REV);
        rb(8'h32, 1'b1);
        sp();
        rd_at(8'h20);
        rb(8'h00, 1'b1);
        sp();
        st();
        sb(AW ^ 8'h02, 1'b0);
        sp();
        $display("test read-only and unmapped done");
        st();
        sb(AW, 1'b1);
        sb(prx_pkg::ADDR_SOFT_RESET, 1'b1);
        sb(8'h01, 1'b1);
        rd_at(prx_pkg::ADDR_LED_DIV);
        rb(8'h08, 1'b1);
        sp();
        repeat (4) @(negedge ref_clk);
        chk("upper threshold", upper_threshold, 16'h0000);
        rd_at(prx_pkg::ADDR_LED_DIV);
        rb(8'h10, 1'b1);
        sp();
        $display("test soft reset done");
        summarize();
    end
endmodule
